//--- core/por_seq_pkg.sv
// constants and carrier types for the power-on io release sequencer
// How it works
// R1 - any supply low asserts supply guard cutoff
// R2 - pins tri-stated until user mode entered
// R3 - weak pull-ups enabled during configuration download
// R4 - download starts when core supply good
// R5 - download finishes within configuration time
// R6 - user mode needs banks good, plus 2us; the 2us wait is skipped if banks are already good when the download ends
// R7 - no supply monitoring once in user mode
// R8 - core cycled low restarts the download
// R9 - registers cleared and released before io
// R10 - clear pin option holds registers cleared
// R11 - output enable option holds tri-states longer
// R12 - synchronised inputs, counted delays, restart on drop
package por_seq_pkg;
	localparam int  CLK_MHZ        = 200;
	localparam int  N_BANKS        = 4;
	// configuration time in microseconds
	localparam int  CFG_TIME_US    = 200;
	localparam int  CFG_CYC        = CFG_TIME_US * CLK_MHZ;
	localparam int  BANK_DLY_US    = 2;
	localparam int  BANK_DLY_CYC   = BANK_DLY_US * CLK_MHZ;
	localparam int  CNT_W          = 17;
	localparam logic [CNT_W-1:0] CNT_RST = 17'h00000;

	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_LOAD  = 3'b001,
		ST_BANKW = 3'b011,
		ST_CLR   = 3'b010,
		ST_USER  = 3'b110
	} seq_state_t;

	typedef struct packed {
		logic core_good;
		logic [N_BANKS-1:0] bank_good;
	} supply_t;

	typedef struct packed {
		logic dev_clr_en;
		logic device_wide_output_enable_en;
	} option_t;
endpackage : por_seq_pkg

//--- core/power_on_io_release_sequencer.sv
// power-on sequencing: supply guard, download timing, io release
`timescale 1ns/1ps
module power_on_io_release_sequencer #(
	parameter int CFG_CYCLES = por_seq_pkg::CFG_CYC
) (
	input  wire logic                i_core_clk,   // 200 MHz time base
	input  wire logic                i_nrst,       // sync reset, low
	input  wire por_seq_pkg::supply_t i_supply,    // supply good, async
	input  wire por_seq_pkg::option_t i_options,   // pin options, static
	input  wire logic                i_device_wide_clear_n,      // pin
	input  wire logic                i_device_wide_output_enable, // pin
	output logic                     o_supply_guard_cutoff, // buffers off
	output logic                     o_io_oe_n,     // low: user drives io
	output logic                     o_weak_pullup, // download pull-ups
	output logic                     o_download,    // config in progress
	output logic                     o_reg_clear,   // core regs held clear
	output logic                     o_user_mode    // user mode entered
);
	// ***************
	// synchronisers
	// ***************
	localparam int SW = por_seq_pkg::N_BANKS + 3;
	logic [SW-1:0] meta_r;
	logic [SW-1:0] sync_r;
	always_ff @(posedge i_core_clk)
		if (!i_nrst)
		begin
			meta_r <= '0;
			sync_r <= '0;
		end
		else
		begin
			meta_r <= {i_supply, i_device_wide_clear_n,
				i_device_wide_output_enable};
			sync_r <= meta_r;
		end

	logic core_ok;
	logic banks_ok;
	logic clr_n_s;
	logic oe_s;
	assign core_ok  = sync_r[SW-1]; // R12
	assign banks_ok = &sync_r[SW-2:2];
	assign clr_n_s  = sync_r[1];
	assign oe_s     = sync_r[0];

	// ***************
	// sequencer
	// ***************
	por_seq_pkg::seq_state_t state_r;
	logic [por_seq_pkg::CNT_W-1:0] cnt_r;
	localparam logic [por_seq_pkg::CNT_W-1:0] CFG_LAST =
		por_seq_pkg::CNT_W'(CFG_CYCLES - 1);
	localparam logic [por_seq_pkg::CNT_W-1:0] BANK_LAST =
		por_seq_pkg::CNT_W'(por_seq_pkg::BANK_DLY_CYC - 1);

	// one increment for the sequencer and the assertion helpers
	function automatic logic [por_seq_pkg::CNT_W-1:0] cnt_inc(
		input logic [por_seq_pkg::CNT_W-1:0] c
	);
		return c + por_seq_pkg::CNT_W'(1);
	endfunction : cnt_inc

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
		begin
			state_r <= por_seq_pkg::ST_OFF;
			cnt_r   <= por_seq_pkg::CNT_RST;
		end
		else
		begin
			unique case (state_r)
			por_seq_pkg::ST_OFF:
				if (core_ok)                                   // R4 R8
				begin
					state_r <= por_seq_pkg::ST_LOAD;
					cnt_r   <= por_seq_pkg::CNT_RST;
				end
			por_seq_pkg::ST_LOAD:
				if (!core_ok)                                  // R12
					state_r <= por_seq_pkg::ST_OFF;
				else if (cnt_r == CFG_LAST)                    // R5
				begin
					cnt_r   <= por_seq_pkg::CNT_RST;
					// banks already good: no extra wait
					state_r <= banks_ok ? por_seq_pkg::ST_CLR
						: por_seq_pkg::ST_BANKW;
				end
				else
					cnt_r <= cnt_inc(cnt_r);
			por_seq_pkg::ST_BANKW:
				if (!core_ok)
					state_r <= por_seq_pkg::ST_OFF;
				else if (!banks_ok)                            // R6
					cnt_r <= por_seq_pkg::CNT_RST;
				else if (cnt_r == BANK_LAST)                   // R6
					state_r <= por_seq_pkg::ST_CLR;
				else
					cnt_r <= cnt_inc(cnt_r);
			por_seq_pkg::ST_CLR:
				// one cycle of clear before io release
				if (!core_ok)
					state_r <= por_seq_pkg::ST_OFF;
				else
					state_r <= por_seq_pkg::ST_USER;             // R9
			por_seq_pkg::ST_USER:
				// supplies ignored: only reset leaves here
				state_r <= por_seq_pkg::ST_USER;               // R7
			default:
				state_r <= por_seq_pkg::ST_OFF;
			endcase
		end

	// ***************
	// outputs
	// ***************
	logic user;
	assign user = (state_r == por_seq_pkg::ST_USER);

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_supply_guard_cutoff <= 1'b1;
		else
			// in user mode the guard no longer follows supplies
			o_supply_guard_cutoff <= !user &&
				!(core_ok && banks_ok);                       // R1 R7

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_io_oe_n <= 1'b1;
		else
			o_io_oe_n <= !(user &&
				(!i_options.device_wide_output_enable_en || oe_s));              // R2 R11

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_weak_pullup <= 1'b1;
		else
			o_weak_pullup <= !user;                          // R3

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_download <= 1'b0;
		else
			o_download <= (state_r == por_seq_pkg::ST_LOAD);

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_reg_clear <= 1'b1;
		else
			o_reg_clear <= !(state_r == por_seq_pkg::ST_CLR || user) ||
				(i_options.dev_clr_en && !clr_n_s);           // R9 R10

	always_ff @(posedge i_core_clk)
		if (!i_nrst)
			o_user_mode <= 1'b0;
		else
			o_user_mode <= user;

	// ***************
	// assertion helpers
	// ***************
	// saturating, so a stuck state cannot wrap back to zero
	logic [por_seq_pkg::CNT_W-1:0] dl_len_r;
	logic [por_seq_pkg::CNT_W-1:0] bank_run_r;

	always_ff @(posedge i_core_clk)
		if (!i_nrst || !o_download)
			dl_len_r <= por_seq_pkg::CNT_RST;
		else if (dl_len_r != '1)
			dl_len_r <= cnt_inc(dl_len_r);

	// banks good without a break, counted apart from the sequencer
	always_ff @(posedge i_core_clk)
		if (!i_nrst || !banks_ok)
			bank_run_r <= por_seq_pkg::CNT_RST;
		else if (bank_run_r != '1)
			bank_run_r <= cnt_inc(bank_run_r);

	// ***************
	// assertions
	// ***************
	sequence s_load_done;
		state_r == por_seq_pkg::ST_LOAD && cnt_r == CFG_LAST && core_ok;
	endsequence
	sequence s_clr_to_user;
		state_r == por_seq_pkg::ST_CLR && core_ok ##1
		state_r == por_seq_pkg::ST_USER;
	endsequence
	sequence s_bank_done;
		state_r == por_seq_pkg::ST_BANKW ##1
		state_r == por_seq_pkg::ST_CLR;
	endsequence

	property p_guard;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(!user && !(core_ok && banks_ok)) |=>
			o_supply_guard_cutoff;
	endproperty
	a_guard: assert property (p_guard) else $error("guard low"); // R1

	property p_tristate;
		@(posedge i_core_clk) disable iff (!i_nrst)
		!user |=> o_io_oe_n;
	endproperty
	a_tristate: assert property (p_tristate) else $error("io early"); // R2

	property p_pullup;
		@(posedge i_core_clk) disable iff (!i_nrst)
		o_download |-> o_weak_pullup;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pullup off"); // R3

	property p_start;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_r == por_seq_pkg::ST_OFF && core_ok) |=> ##1 o_download;
	endproperty
	a_start: assert property (p_start) else $error("no start"); // R4

	property p_cfg_end;
		@(posedge i_core_clk) disable iff (!i_nrst)
		s_load_done |=> state_r != por_seq_pkg::ST_LOAD;
	endproperty
	a_cfg_end: assert property (p_cfg_end) else $error("load long"); // R5

	property p_bank_gate;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(state_r == por_seq_pkg::ST_BANKW && !banks_ok) |=>
			state_r != por_seq_pkg::ST_CLR;
	endproperty
	a_bank_gate: assert property (p_bank_gate) else $error("bank"); // R6

	property p_user_hold;
		@(posedge i_core_clk) disable iff (!i_nrst)
		user |=> user;
	endproperty
	a_user_hold: assert property (p_user_hold) else $error("left user"); // R7

	property p_restart;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(!user && !core_ok) |=> state_r == por_seq_pkg::ST_OFF;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart"); // R12

	property p_clr_first;
		@(posedge i_core_clk) disable iff (!i_nrst)
		s_clr_to_user |-> o_io_oe_n;
	endproperty
	a_clr_first: assert property (p_clr_first) else $error("order"); // R9

	property p_devclr;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(i_options.dev_clr_en && !clr_n_s) |=> o_reg_clear;
	endproperty
	a_devclr: assert property (p_devclr) else $error("clr pin"); // R10

	property p_devoe;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(i_options.device_wide_output_enable_en && !oe_s) |=> o_io_oe_n;
	endproperty
	a_devoe: assert property (p_devoe) else $error("oe pin"); // R11

	property p_dl_len;
		@(posedge i_core_clk) disable iff (!i_nrst)
		o_download |-> dl_len_r <= CFG_LAST;
	endproperty
	a_dl_len: assert property (p_dl_len) else $error("overrun"); // R5

	property p_bank_late;
		@(posedge i_core_clk) disable iff (!i_nrst)
		s_load_done ##0 !banks_ok |=> state_r == por_seq_pkg::ST_BANKW;
	endproperty
	a_bank_late: assert property (p_bank_late) else $error("no wait"); // R6

	property p_bank_delay;
		@(posedge i_core_clk) disable iff (!i_nrst)
		s_bank_done |-> bank_run_r > BANK_LAST;
	endproperty
	a_bank_delay: assert property (p_bank_delay) else $error("short"); // R6

	property p_guard_user;
		@(posedge i_core_clk) disable iff (!i_nrst)
		user |=> !o_supply_guard_cutoff;
	endproperty
	a_guard_user: assert property (p_guard_user) else $error("guard"); // R7

	property p_release;
		@(posedge i_core_clk) disable iff (!i_nrst)
		(user && (!i_options.device_wide_output_enable_en || oe_s)) |=> !o_io_oe_n;
	endproperty
	a_release: assert property (p_release) else $error("io kept"); // R11

	property p_clr_io;
		@(posedge i_core_clk) disable iff (!i_nrst)
		($fell(o_io_oe_n) && !i_options.dev_clr_en) |-> !o_reg_clear;
	endproperty
	a_clr_io: assert property (p_clr_io) else $error("clear late"); // R9

	property p_pullup_hold;
		@(posedge i_core_clk) disable iff (!i_nrst)
		!user |=> o_weak_pullup;
	endproperty
	a_pullup_hold: assert property (p_pullup_hold) else $error("pu"); // R3
endmodule : power_on_io_release_sequencer

//--- dv/test_power_on_io_release_sequencer.sv
// self-checking bench for the power-on io release sequencer
`timescale 1ns/1ps
module test_power_on_io_release_sequencer;
	// ****************
	// bench signals
	// ****************
	localparam int CFG = 20;
	localparam int BDLY = por_seq_pkg::BANK_DLY_CYC;
	logic                 clk = 1'b0;
	logic                 nrst = 1'b0;
	por_seq_pkg::supply_t sup = '0;
	por_seq_pkg::option_t opt = '0;
	logic                 clr_n = 1'b1;
	logic                 oe = 1'b0;
	logic                 grd, oe_n, pu, dl, rclr, usr;
	int                   error_cnt = 0;
	int                   checks_done = 0;
	int                   n;

	initial forever #2.5 clk = ~clk;

	power_on_io_release_sequencer #(.CFG_CYCLES(CFG)) uut (
		.i_core_clk(clk), .i_nrst(nrst), .i_supply(sup), .i_options(opt),
		.i_device_wide_clear_n(clr_n), .i_device_wide_output_enable(oe),
		.o_supply_guard_cutoff(grd), .o_io_oe_n(oe_n), .o_weak_pullup(pu),
		.o_download(dl), .o_reg_clear(rclr), .o_user_mode(usr));

	// ****************
	// shared tasks
	// ****************
	// inputs move 1 ns after the edge, outputs are settled by then
	task automatic step(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : step

	task automatic chk(input logic got, input logic exp, input string m);
		checks_done++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi,
			input string m);
		chk(got >= lo && got <= hi, 1'b1, m);
	endtask : chk_rng

	// options are straps, so they only change inside reset
	task automatic rst(input por_seq_pkg::option_t o);
		nrst = 1'b0;
		sup = '0;
		opt = o;
		step(6);
		nrst = 1'b1;
	endtask : rst

	task automatic wait_user(input int lim, output int c);
		c = 0;
		while (usr !== 1'b1 && c < lim)
		begin
			step(1);
			c++;
			if (oe_n === 1'b0)
				chk(rclr, opt.dev_clr_en && !clr_n, "io first");
		end
	endtask : wait_user

	// ****************
	// scenarios
	// ****************
	task automatic t_power();
		rst(2'b00);
		chk(grd, 1'b1, "guard low, supplies off");
		chk(oe_n, 1'b1, "io not held");
		sup = 5'h1F;
		step(6);
		chk(dl, 1'b1, "no download");
		chk(pu, 1'b1, "pull-up off");
		chk(grd, 1'b0, "guard held, supplies good");
		wait_user(CFG + 40, n);
		chk_rng(n, CFG - 6, CFG + 6, "config time");
		step(2);
		chk(oe_n, 1'b0, "io held in user");
		chk(pu, 1'b0, "pull-up on in user");
		chk(rclr, 1'b0, "regs held clear");
		sup = '0;
		step(10);
		chk(usr, 1'b1, "user mode lost");
		chk(grd, 1'b0, "guard in user");
		$display("t_power done");
	endtask : t_power

	task automatic t_late();
		rst(2'b00);
		sup = 5'h10;
		step(CFG + 30);
		chk(usr, 1'b0, "user without banks");
		chk(grd, 1'b1, "guard low, bank off");
		sup = 5'h1F;
		wait_user(600, n);
		chk_rng(n, BDLY, BDLY + 10, "bank delay");
		$display("t_late done");
	endtask : t_late

	task automatic t_restart();
		rst(2'b00);
		sup = 5'h1F;
		step(CFG / 2);
		sup = 5'h0F;
		step(5);
		chk(dl, 1'b0, "download kept");
		sup = 5'h1F;
		wait_user(CFG + 40, n);
		chk_rng(n, CFG, CFG + 10, "restart time");
		$display("t_restart done");
	endtask : t_restart

	task automatic t_pins();
		rst(2'b01);
		oe = 1'b0;
		sup = 5'h1F;
		wait_user(CFG + 40, n);
		step(20);
		chk(oe_n, 1'b1, "oe pin ignored");
		oe = 1'b1;
		step(6);
		chk(oe_n, 1'b0, "io not released");
		rst(2'b10);
		clr_n = 1'b0;
		sup = 5'h1F;
		wait_user(CFG + 40, n);
		step(10);
		chk(rclr, 1'b1, "clear pin ignored");
		clr_n = 1'b1;
		step(6);
		chk(rclr, 1'b0, "clear not released");
		$display("t_pins done");
	endtask : t_pins

	// ****************
	// verdict
	// ****************
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		step(1);
		t_power();
		t_late();
		t_restart();
		t_pins();
		tally_and_finish();
	end

	// whole run needs about 650 cycles
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : test_power_on_io_release_sequencer
